//--- design/mmd_decode.sv
`timescale 1ns/1ps
module mmd_decode (
   // Clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   // Program fetch side
   input  wire logic [12:0]            pc_in,
   input  wire logic                   pc_load,
   input  wire logic                   irq_take,
   output logic      [12:0]            fetch_pc,
   output logic      [10:0]            prog_addr,
   // Data side
   input  wire mmd_pkg::mmd_dreq_t     dreq,
   input  wire logic [7:0]             status_in,
   input  wire logic [7:0]             indirect_pointer_register,
   output logic      [7:0]             rdata,
   output logic                        rvalid,
   output logic      [7:0]             resolved_addr,
   output logic                        hit_sf,
   output logic                        hit_gp
);
   logic [12:0]        pc_reg;
   logic [12:0]        pc_next;
   logic               bank_select_bit;
   logic [7:0]         eff_addr;
   logic [7:0]         ind_addr;
   mmd_pkg::mmd_tgt_t  tgt;
   logic [6:0]         gp_idx;
   logic [5:0]         sf_idx;
   logic               gp_we;
   logic               sf_we;
   logic [7:0]         gp_rd;
   logic [7:0]         sf_rd;
   mmd_pkg::mmd_tgt_t  tgt_reg;
   logic               rd_pend_reg;

   // Program counter: vector on interrupt, otherwise follow the core
   always_comb begin
      if (irq_take) begin
         pc_next = mmd_pkg::IRQ_VEC;
      end else if (pc_load) begin
         pc_next = pc_in;
      end else begin
         pc_next = pc_reg;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pc_reg <= mmd_pkg::RESET_VEC;
      end else begin
         pc_reg <= pc_next;
      end
   end

   // Only the low 11 bits reach the array, so high pages alias onto it
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         fetch_pc  <= mmd_pkg::RESET_VEC;
         prog_addr <= 11'h000;
      end else begin
         fetch_pc  <= pc_next;
         prog_addr <= pc_next[10:0];
      end
   end

   // Bank bit and address formation
   assign bank_select_bit = status_in[mmd_pkg::BANK_BIT];
   assign ind_addr        = indirect_pointer_register;
   assign eff_addr        = dreq.indirect ? ind_addr
                                          : {bank_select_bit, dreq.dir_addr};

   // Map an 8-bit data address onto a physical cell or nothing
   always_comb begin
      tgt    = mmd_pkg::MMD_TGT_NONE;
      gp_idx = 7'h00;
      sf_idx = {eff_addr[7], eff_addr[4:0]};
      if (eff_addr[6:0] <= mmd_pkg::SF_TOP[6:0]) begin
         // Indirect slot holds no storage of its own
         if (eff_addr[6:0] != mmd_pkg::INDIRECT_AD[6:0]) begin
            tgt = mmd_pkg::MMD_TGT_SF;
         end
      end else if (eff_addr >= mmd_pkg::GP0_LO && eff_addr <= mmd_pkg::GP0_HI) begin
         tgt    = mmd_pkg::MMD_TGT_GP;
         gp_idx = eff_addr[6:0] - mmd_pkg::GP0_LO[6:0];
      end else if (eff_addr >= mmd_pkg::GP1_LO && eff_addr <= mmd_pkg::GP1_HI) begin
         tgt    = mmd_pkg::MMD_TGT_GP;
         gp_idx = mmd_pkg::GP1_BASE + {2'b00, eff_addr[4:0]};
      end else if (eff_addr >= mmd_pkg::MIR_LO) begin
         tgt    = mmd_pkg::MMD_TGT_GP;
         gp_idx = eff_addr[6:0] - mmd_pkg::GP0_LO[6:0];
      end
   end

   assign gp_we = dreq.req && dreq.wr && (tgt == mmd_pkg::MMD_TGT_GP);
   assign sf_we = dreq.req && dreq.wr && (tgt == mmd_pkg::MMD_TGT_SF);

   // 96 bank-zero bytes plus 32 bank-one bytes in one array
   mmd_ram #(
      .AW (mmd_pkg::GP_AW),
      .DW (mmd_pkg::DATA_W)
   ) u_gp_ram (
      .clk_sys (clk_sys),
      .we      (gp_we),
      .addr    (gp_idx),
      .wdata   (dreq.wdata),
      .rdata   (gp_rd)
   );

   // Special locations kept as plain cells; peripherals live elsewhere
   mmd_ram #(
      .AW (mmd_pkg::SF_AW),
      .DW (mmd_pkg::DATA_W)
   ) u_sf_ram (
      .clk_sys (clk_sys),
      .we      (sf_we),
      .addr    (sf_idx),
      .wdata   (dreq.wdata),
      .rdata   (sf_rd)
   );

   // Remember the target so the answer lines up with the array output
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tgt_reg     <= mmd_pkg::MMD_TGT_NONE;
         rd_pend_reg <= 1'b0;
      end else begin
         tgt_reg     <= tgt;
         rd_pend_reg <= dreq.req && !dreq.wr;
      end
   end

   // Decode report, registered with the request
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         resolved_addr <= mmd_pkg::ZERO_BYTE;
         hit_sf        <= 1'b0;
         hit_gp        <= 1'b0;
      end else begin
         resolved_addr <= eff_addr;
         hit_sf        <= dreq.req && (tgt == mmd_pkg::MMD_TGT_SF);
         hit_gp        <= dreq.req && (tgt == mmd_pkg::MMD_TGT_GP);
      end
   end

   // Read answer one cycle after the ram output, zero for holes
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdata  <= mmd_pkg::ZERO_BYTE;
         rvalid <= 1'b0;
      end else begin
         rvalid <= rd_pend_reg;
         case (tgt_reg)
            mmd_pkg::MMD_TGT_GP: rdata <= gp_rd;
            mmd_pkg::MMD_TGT_SF: rdata <= sf_rd;
            default:             rdata <= mmd_pkg::ZERO_BYTE;
         endcase
      end
   end
endmodule : mmd_decode

//--- design/mmd_pkg.sv
package mmd_pkg;
   // Program space
   localparam int unsigned PC_W        = 13;
   localparam int unsigned PROG_W      = 11;
   localparam int unsigned INSTR_W     = 14;
   localparam logic [12:0] RESET_VEC   = 13'h0000;
   localparam logic [12:0] IRQ_VEC     = 13'h0004;
   // Data space
   localparam int unsigned DATA_W      = 8;
   localparam int unsigned DADDR_W     = 8;
   localparam int unsigned GP_DEPTH    = 128;
   localparam int unsigned GP_AW       = 7;
   localparam int unsigned SF_DEPTH    = 64;
   localparam int unsigned SF_AW       = 6;
   localparam int unsigned BANK_BIT    = 5;
   localparam logic [7:0]  SF_TOP      = 8'h1F;
   localparam logic [7:0]  GP0_LO      = 8'h20;
   localparam logic [7:0]  GP0_HI      = 8'h7F;
   localparam logic [7:0]  GP1_LO      = 8'hA0;
   localparam logic [7:0]  GP1_HI      = 8'hBF;
   localparam logic [7:0]  MIR_LO      = 8'hF0;
   localparam logic [7:0]  INDIRECT_AD = 8'h00;
   localparam logic [7:0]  ZERO_BYTE   = 8'h00;
   localparam logic [6:0]  GP1_BASE    = 7'h60;

   // Decoded target of a data access
   typedef enum logic [1:0] {
      MMD_TGT_NONE,
      MMD_TGT_SF,
      MMD_TGT_GP
   } mmd_tgt_t;

   // Data access request from the core
   typedef struct packed {
      logic       req;
      logic       wr;
      logic       indirect;
      logic [6:0] dir_addr;
      logic [7:0] wdata;
   } mmd_dreq_t;
endpackage : mmd_pkg

//--- design/mmd_ram.sv
`timescale 1ns/1ps
module mmd_ram #(
   parameter int unsigned AW = 7,
   parameter int unsigned DW = 8
) (
   // Clock
   input  wire logic          clk_sys,
   // Access
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wdata,
   output logic      [DW-1:0] rdata
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // Synchronous write and registered read; no reset, like plain static cells
   always_ff @(posedge clk_sys) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule : mmd_ram

//--- verif/mmd_decode_sva.sv
`timescale 1ns/1ps
module mmd_decode_sva (
   // Clock and reset
   input wire logic               clk_sys,
   input wire logic               rst,
   // Program side
   input wire logic [12:0]        pc_in,
   input wire logic               pc_load,
   input wire logic               irq_take,
   input wire logic [12:0]        fetch_pc,
   input wire logic [10:0]        prog_addr,
   // Data side
   input wire mmd_pkg::mmd_dreq_t dreq,
   input wire logic [7:0]         status_in,
   input wire logic [7:0]         indirect_pointer_register,
   input wire logic [7:0]         rdata,
   input wire logic               rvalid,
   input wire logic [7:0]         resolved_addr,
   input wire logic               hit_sf,
   input wire logic               hit_gp
);
   // One domain, so clock and reset are stated once
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Program and data relations
   AST_WRAP: assert property (prog_addr == fetch_pc[10:0]) else $error("no wrap");
   AST_IRQ: assert property (irq_take |=> fetch_pc == 13'h0004) else $error("bad vector");
   AST_LOAD: assert property (pc_load && !irq_take |=> fetch_pc == $past(pc_in)) else $error("bad load");
   AST_DIR: assert property (dreq.req && !dreq.indirect |=>
      resolved_addr == {$past(status_in[5]), $past(dreq.dir_addr)}) else $error("bad direct");
   AST_IND: assert property (dreq.req && dreq.indirect |=>
      resolved_addr == $past(indirect_pointer_register)) else $error("bad indirect");
   AST_RVAL: assert property (dreq.req && !dreq.wr |-> ##2 rvalid) else $error("no read");
   AST_SF: assert property (hit_sf |-> resolved_addr[6:5] == 2'b00) else $error("bad special");
   AST_GP: assert property (hit_gp |-> resolved_addr inside
      {[8'h20:8'h7F], [8'hA0:8'hBF], [8'hF0:8'hFF]}) else $error("bad general");
   AST_ZERO: assert property (rvalid && !$past(hit_sf) && !$past(hit_gp)
      |-> rdata == 8'h00) else $error("not zero");
endmodule : mmd_decode_sva
bind mmd_decode mmd_decode_sva mmd_decode_sva_inst (.*);

//--- verif/mmd_core_model.sv
`timescale 1ns/1ps
module mmd_core_model (
   // Access target
   input wire logic [7:0] target,
   // Core registers
   output logic     [7:0] status_out,
   output logic     [7:0] pointer_out
);
   // Reserved status bits stay zero; bank bit is the target's top bit
   assign status_out  = {2'b00, target[7], 5'h00};
   assign pointer_out = target;
endmodule : mmd_core_model

//--- verif/mmd_decode_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
   $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module mmd_decode_tb;
   typedef struct packed {logic [7:0] wa, ra, d, e;} mmd_row_t;
   // Write address, read address, data, expected read
   localparam mmd_row_t ROWS [8] = '{32'h2020_1111, 32'hA0A0_2222, 32'h70F0_5A5A, 32'h7FFF_5C5C,
      32'hC0C0_3300, 32'h0505_4444, 32'h8505_6644, 32'h0000_7700};
   localparam logic [12:0] PCS [4] = '{13'h0805, 13'h1FFF, 13'h0800, 13'h07FF};
   logic clk_sys = 0, rst = 1, pc_load = 0, irq_take = 0, rvalid, hit_sf, hit_gp;
   logic [12:0] pc_in = 13'h0000, fetch_pc;
   logic [10:0] prog_addr;
   logic [7:0] target = 8'h00, status_in, ptr, rdata, resolved_addr;
   mmd_pkg::mmd_dreq_t dreq = '0;
   int failures = 0, num_checks = 0, cycles = 0;
   // Design and core model
   mmd_decode mmd_decode_inst (.clk_sys(clk_sys), .rst(rst), .pc_in(pc_in), .pc_load(pc_load),
      .irq_take(irq_take), .fetch_pc(fetch_pc), .prog_addr(prog_addr), .dreq(dreq),
      .status_in(status_in), .indirect_pointer_register(ptr), .rdata(rdata), .rvalid(rvalid),
      .resolved_addr(resolved_addr), .hit_sf(hit_sf), .hit_gp(hit_gp));
   mmd_core_model mmd_core_model_inst (.target(target), .status_out(status_in), .pointer_out(ptr));
   // Clock
   always #5 clk_sys = ~clk_sys;
   // A hang is cut short well beyond the expected run
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         print_verdict();
      end
   end
   // One access, held through its edge; rvalid stands only in the second cycle after it
   task automatic acc(input logic wr, ind, input logic [7:0] a, d);
      target = a;
      dreq = '{1'b1, wr, ind, a[6:0], d};
      @(negedge clk_sys) dreq.req = 1'b0;
      @(negedge clk_sys);
   endtask : acc
   task automatic print_verdict();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : print_verdict
   // Main sequence
   initial begin
      repeat (12) @(negedge clk_sys);
      rst = 1'b0;
      foreach (ROWS[i]) begin
         acc(1'b1, 1'b0, ROWS[i].wa, ROWS[i].d);
         acc(1'b0, 1'b1, ROWS[i].ra, 8'h00);
         `CHK(rvalid, 1'b1)
         `CHK(rdata, ROWS[i].e)
      end
      $display("test data map done");
      foreach (PCS[i]) begin
         pc_in = PCS[i];
         pc_load = 1'b1;
         @(negedge clk_sys) pc_load = 1'b0;
         `CHK(fetch_pc, PCS[i])
         `CHK(prog_addr, PCS[i][10:0])
      end
      $display("test program wrap done");
      pc_load = 1'b1;
      irq_take = 1'b1;
      @(negedge clk_sys) {pc_load, irq_take} = 2'b00;
      `CHK(fetch_pc, 13'h0004)
      rst = 1'b1;
      @(negedge clk_sys) `CHK(fetch_pc, 13'h0000)
      rst = 1'b0;
      acc(1'b0, 1'b0, 8'hA0, 8'h00);
      `CHK(rvalid, 1'b1)
      `CHK(rdata, 8'h22)
      $display("test vectors and reset done");
      print_verdict();
   end
endmodule : mmd_decode_tb
